// [design/pss_selector.sv]
// module: preset speed and jog selector with an apb register file
`timescale 1ns/10ps
module pss_selector #(
    parameter int NUM_TERM = pss_pkg::NUM_TERM
) (
    input wire logic clk,
    input wire logic rst,
    input wire pss_pkg::pss_apb_req_t apbReq,
    output pss_pkg::pss_apb_rsp_t apbRsp,
    input wire logic [NUM_TERM-1:0] termPin,
    input wire logic forwardStartPin,
    input wire logic reverseStartPin,
    input wire logic [15:0] currentFreq,
    input wire logic currentValid,
    input wire logic [15:0] voltageFreq,
    output pss_pkg::pss_drive_t drive
);

    if (NUM_TERM < 3 || NUM_TERM > 8) begin : g_check
        $error("pss_selector: NUM_TERM must lie in 3..8");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [pss_pkg::NUM_PRESET-1:0][15:0] preset;
        logic [15:0] inchFreq;
        logic [15:0] inchRamp;
        logic [15:0] rampRef;
        logic rampInc;
        logic [1:0] remoteFn;
        logic [1:0] pws;
        logic [2:0] opMode;
        logic panelInch;
        logic panelRun;
        logic panelRev;
        logic [NUM_TERM-1:0][3:0] termFn;
        logic [NUM_TERM+1:0] pinMeta;
        logic [NUM_TERM+1:0] pinSync;
        logic [31:0] prdata;
        pss_pkg::pss_drive_t drive;
    } pss_state_t;

    pss_state_t state_reg;
    pss_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // contact decode

    logic [NUM_TERM-1:0] termLevel;
    logic fwdLevel;
    logic revLevel;
    logic lowSel;
    logic middleSel;
    logic highSel;
    logic extSel;
    logic inchSel;
    logic secondSel;
    logic [NUM_TERM-1:0] isLow;
    logic [NUM_TERM-1:0] isMiddle;
    logic [NUM_TERM-1:0] isHigh;
    logic [NUM_TERM-1:0] isExt;
    logic [NUM_TERM-1:0] isInch;
    logic [NUM_TERM-1:0] isSecond;

    assign termLevel = state_reg.pinSync[NUM_TERM-1:0];
    assign fwdLevel = state_reg.pinSync[NUM_TERM];
    assign revLevel = state_reg.pinSync[NUM_TERM+1];

    for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
        logic [3:0] fn;
        assign fn = state_reg.termFn[t];
        assign isLow[t] = termLevel[t] && (fn == pss_pkg::FN_LOW); // RL11
        assign isMiddle[t] = termLevel[t] && (fn == pss_pkg::FN_MIDDLE); // RL11
        assign isHigh[t] = termLevel[t] && (fn == pss_pkg::FN_HIGH); // RL11
        assign isExt[t] = termLevel[t] && (fn == pss_pkg::FN_EXTENSION); // RL12
        assign isInch[t] = termLevel[t] && (fn == pss_pkg::FN_INCH); // RL13
        assign isSecond[t] = termLevel[t] && (fn == pss_pkg::FN_SECOND);
    end

    assign lowSel = |isLow;
    assign middleSel = |isMiddle;
    assign highSel = |isHigh;
    assign extSel = |isExt;
    assign inchSel = |isInch;
    assign secondSel = |isSecond;

    ////////////////////////////////////////////////////////////////////////////////
    // preset lookup

    // contact code {ext, high, middle, low} to preset slot; 15 marks a code with no extension and at most one base contact
    function automatic logic [3:0] ext_slot(input logic [3:0] code);
        logic [3:0] slot;
        slot = 4'hF;
        case (code)
            4'b0011: slot = 4'h3;
            4'b0101: slot = 4'h4;
            4'b0110: slot = 4'h5;
            4'b0111: slot = 4'h6;
            4'b1000: slot = 4'h7;
            4'b1001: slot = 4'h8;
            4'b1010: slot = 4'h9;
            4'b1011: slot = 4'hA;
            4'b1100: slot = 4'hB;
            4'b1101: slot = 4'hC;
            4'b1110: slot = 4'hD;
            4'b1111: slot = 4'hE;
            default: slot = 4'hF;
        endcase
        return slot;
    endfunction

    logic [3:0] contactCode;
    logic [3:0] extIdx;
    logic [15:0] extFreq;
    logic extValid;
    logic presetEnable;
    logic presetHit;
    logic [15:0] presetFreq;

    assign contactCode = {extSel, highSel, middleSel, lowSel};
    assign extIdx = ext_slot(contactCode); // RL3 RL9
    assign extFreq = (extIdx == 4'hF) ? pss_pkg::PRESET_UNSET : state_reg.preset[extIdx];
    assign extValid = (extFreq != pss_pkg::PRESET_UNSET); // RL4

    assign presetEnable = (state_reg.opMode == pss_pkg::MODE_EXTERNAL
                        || state_reg.opMode == pss_pkg::MODE_COMBINED) // RL7
                        && (state_reg.remoteFn == 2'h0); // RL10

    always_comb begin
        presetHit = 1'b1;
        presetFreq = '0;
        if (extValid) begin
            presetFreq = extFreq; // RL3
        end else if (lowSel || (extSel && !highSel && !middleSel)) begin
            // unset speed 8 with extension alone drops to the low preset
            presetFreq = state_reg.preset[pss_pkg::IDX_LOW]; // RL2 RL5
        end else if (middleSel) begin
            presetFreq = state_reg.preset[pss_pkg::IDX_MIDDLE]; // RL2
        end else if (highSel) begin
            presetFreq = state_reg.preset[pss_pkg::IDX_HIGH]; // RL1
        end else begin
            presetHit = 1'b0;
        end
        if (!presetEnable) begin
            presetHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // source selection

    logic inchAllowed;
    logic extStart;
    logic panelStart;
    logic anyStart;
    logic inchNow;
    logic inchMode;

    assign inchAllowed = (state_reg.opMode != pss_pkg::MODE_EXTERNAL); // RL20
    assign extStart = fwdLevel || revLevel;
    assign panelStart = state_reg.panelRun;
    assign anyStart = extStart || panelStart;
    // external jog selection or panel jog mode, both gated by a held start
    assign inchMode = inchAllowed && (inchSel || state_reg.panelInch); // RL18
    assign inchNow = inchMode && anyStart; // RL17

    pss_pkg::pss_drive_t driveNext;

    always_comb begin
        driveNext = '0;
        driveNext.rampTime = '0;
        if (inchMode) begin
            driveNext.freq = state_reg.inchFreq; // RL14
            driveNext.src = pss_pkg::SRC_INCH; // RL6
            driveNext.rampTime = state_reg.inchRamp; // RL15
        end else if (presetHit) begin
            driveNext.freq = presetFreq;
            driveNext.src = pss_pkg::SRC_PRESET; // RL6
        end else if (currentValid) begin
            driveNext.freq = currentFreq; // RL22
            driveNext.src = pss_pkg::SRC_CURRENT; // RL6
        end else begin
            driveNext.freq = voltageFreq; // RL22
            driveNext.src = pss_pkg::SRC_VOLTAGE; // RL6
        end
        driveNext.inchActive = inchNow;
        // forward wins a tie with reverse; panel run uses the panel direction
        if (extStart) begin
            driveNext.runFwd = fwdLevel; // RL17
            driveNext.runRev = revLevel && !fwdLevel; // RL17
        end else if (panelStart) begin
            driveNext.runFwd = !state_reg.panelRev;
            driveNext.runRev = state_reg.panelRev;
        end
        if (inchMode && !anyStart) begin
            driveNext.freq = '0; // RL17
        end
        driveNext.rampFine = state_reg.rampInc; // RL16
        driveNext.rampRef = state_reg.rampRef; // RL15
        driveNext.secondRampSel = secondSel && !inchMode; // RL21
        driveNext.secondOtherSel = secondSel; // RL21
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic setup;
    logic access;
    logic doWrite;
    logic running;
    logic lockCfg;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [5:0] word;
    logic isPresetAddr;
    logic isTermAddr;
    logic [3:0] presetSlot;
    logic [2:0] termSlot;
    logic mapped;
    logic badValue;

    assign setup = apbReq.psel && !apbReq.penable;
    assign access = apbReq.psel && apbReq.penable;
    assign addr = apbReq.paddr;
    assign wdata = apbReq.pwdata;
    assign word = addr[7:2];
    assign presetSlot = word[3:0];
    assign termSlot = addr[4:2];
    assign isPresetAddr = (addr[7:6] == 2'b00) && (presetSlot < 4'hF) && (addr[1:0] == 2'b00);
    assign isTermAddr = (addr[7:5] == 3'b011) && (int'(termSlot) < NUM_TERM)
                     && (addr[1:0] == 2'b00);
    assign running = state_reg.drive.runFwd || state_reg.drive.runRev;
    // configuration other than presets and the panel register is frozen while running unless writes always allowed
    assign lockCfg = running && (state_reg.pws != pss_pkg::PWS_ALWAYS);

    always_comb begin
        mapped = 1'b1;
        case (addr)
            pss_pkg::ADDR_INCH_FREQ, pss_pkg::ADDR_INCH_RAMP, pss_pkg::ADDR_RAMP_REF,
            pss_pkg::ADDR_RAMP_INC, pss_pkg::ADDR_REMOTE, pss_pkg::ADDR_PWS,
            pss_pkg::ADDR_OPMODE, pss_pkg::ADDR_PANEL, pss_pkg::ADDR_STAT_FREQ,
            pss_pkg::ADDR_STAT_FLAGS, pss_pkg::ADDR_STAT_PINS: mapped = 1'b1;
            default: mapped = isPresetAddr || isTermAddr;
        endcase
    end

    always_comb begin
        badValue = 1'b0;
        if (!mapped) begin
            badValue = 1'b1;
        end else if (isPresetAddr) begin
            // presets ignore the run lock
            badValue = (wdata[15:0] > pss_pkg::FREQ_MAX)
                    && !((presetSlot > 4'h2) && (wdata[15:0] == pss_pkg::PRESET_UNSET)); // RL8
        end else if (addr == pss_pkg::ADDR_PANEL) begin
            badValue = 1'b0;
        end else if (addr >= pss_pkg::ADDR_STAT_FREQ) begin
            badValue = 1'b1;
        end else if (lockCfg) begin
            badValue = 1'b1;
        end else if (addr == pss_pkg::ADDR_INCH_FREQ) begin
            badValue = (wdata[15:0] > pss_pkg::FREQ_MAX); // RL14
        end else if (addr == pss_pkg::ADDR_INCH_RAMP) begin
            badValue = (wdata[15:0] > pss_pkg::RAMP_MAX); // RL16
        end else if (addr == pss_pkg::ADDR_RAMP_REF) begin
            badValue = (wdata[15:0] > pss_pkg::FREQ_MAX);
        end
    end

    assign doWrite = access && apbReq.pwrite && !badValue;

    always_comb begin
        state_next = state_reg;
        state_next.pinMeta = {reverseStartPin, forwardStartPin, termPin};
        state_next.pinSync = state_reg.pinMeta;
        state_next.drive = driveNext; // RL23
        if (setup) begin
            state_next.prdata = '0;
            if (isPresetAddr) begin
                state_next.prdata[15:0] = state_reg.preset[presetSlot];
            end else if (isTermAddr) begin
                state_next.prdata[3:0] = state_reg.termFn[termSlot];
            end else begin
                case (addr)
                    pss_pkg::ADDR_INCH_FREQ: state_next.prdata[15:0] = state_reg.inchFreq;
                    pss_pkg::ADDR_INCH_RAMP: state_next.prdata[15:0] = state_reg.inchRamp;
                    pss_pkg::ADDR_RAMP_REF: state_next.prdata[15:0] = state_reg.rampRef;
                    pss_pkg::ADDR_RAMP_INC: state_next.prdata[0] = state_reg.rampInc;
                    pss_pkg::ADDR_REMOTE: state_next.prdata[1:0] = state_reg.remoteFn;
                    pss_pkg::ADDR_PWS: state_next.prdata[1:0] = state_reg.pws;
                    pss_pkg::ADDR_OPMODE: state_next.prdata[2:0] = state_reg.opMode;
                    pss_pkg::ADDR_PANEL: state_next.prdata[2:0] =
                        {state_reg.panelRev, state_reg.panelRun, state_reg.panelInch};
                    pss_pkg::ADDR_STAT_FREQ: state_next.prdata[15:0] = state_reg.drive.freq;
                    pss_pkg::ADDR_STAT_FLAGS: state_next.prdata[8:0] = {
                        state_reg.drive.secondOtherSel, state_reg.drive.secondRampSel,
                        state_reg.drive.inchActive, state_reg.drive.runRev,
                        state_reg.drive.runFwd, presetHit, state_reg.drive.src};
                    pss_pkg::ADDR_STAT_PINS: state_next.prdata[NUM_TERM+1:0] =
                        state_reg.pinSync;
                    default: state_next.prdata = '0;
                endcase
            end
        end
        if (doWrite) begin
            if (isPresetAddr) begin
                state_next.preset[presetSlot] = wdata[15:0]; // RL8 RL19
            end else if (isTermAddr) begin
                state_next.termFn[termSlot] = wdata[3:0]; // RL11 RL12 RL13
            end else begin
                case (addr)
                    pss_pkg::ADDR_INCH_FREQ: state_next.inchFreq = wdata[15:0];
                    pss_pkg::ADDR_INCH_RAMP: state_next.inchRamp = wdata[15:0];
                    pss_pkg::ADDR_RAMP_REF: state_next.rampRef = wdata[15:0];
                    pss_pkg::ADDR_RAMP_INC: state_next.rampInc = wdata[0];
                    pss_pkg::ADDR_REMOTE: state_next.remoteFn = wdata[1:0];
                    pss_pkg::ADDR_PWS: state_next.pws = wdata[1:0];
                    pss_pkg::ADDR_OPMODE: state_next.opMode = wdata[2:0];
                    pss_pkg::ADDR_PANEL: begin
                        state_next.panelInch = wdata[0];
                        state_next.panelRun = wdata[1];
                        state_next.panelRev = wdata[2];
                    end
                    default: state_next.opMode = state_reg.opMode;
                endcase
            end
        end
        if (rst) begin
            state_next = '0;
            state_next.preset = {pss_pkg::NUM_PRESET{pss_pkg::PRESET_UNSET}}; // RL4
            state_next.preset[pss_pkg::IDX_HIGH] = pss_pkg::RST_HIGH; // RL1
            state_next.preset[pss_pkg::IDX_MIDDLE] = pss_pkg::RST_MIDDLE; // RL1
            state_next.preset[pss_pkg::IDX_LOW] = pss_pkg::RST_LOW; // RL1
            state_next.inchFreq = pss_pkg::RST_INCH_FREQ; // RL14
            state_next.inchRamp = pss_pkg::RST_INCH_RAMP; // RL15
            state_next.rampRef = pss_pkg::RST_RAMP_REF; // RL15
            state_next.termFn = {NUM_TERM{pss_pkg::RST_TERM_UNUSED}};
            state_next.termFn[0] = pss_pkg::FN_LOW; // RL11
            state_next.termFn[1] = pss_pkg::FN_MIDDLE; // RL11
            state_next.termFn[2] = pss_pkg::FN_HIGH; // RL11
        end
    end

    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // read data is captured in the setup cycle so the access phase needs no wait
    assign apbRsp.prdata = state_reg.prdata;
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = access && badValue && (apbReq.pwrite || !mapped);
    assign drive = state_reg.drive;

endmodule // pss_selector

// [inc/pss_pkg.sv]
// package: constants, register map and carriers of the preset speed and jog selector
// Behaviour
// [RL1] high, middle, low contacts pick their presets
// [RL2] several base contacts: lowest-ranked contact wins
// [RL3] contact combinations select speeds 4 to 15
// [RL4] extended preset 9999 means not selected
// [RL5] speed-8 unset, extension only: low preset
// [RL6] jog over presets over current over voltage
// [RL7] presets act only in modes 3 or 4
// [RL8] preset writes accepted while running, any mode
// [RL9] extended presets carry no mutual priority
// [RL10] remote function nonzero disables preset selection
// [RL11] base contacts routed by function codes 0-2
// [RL12] extension contact needs function code 8
// [RL13] jog select needs function code 5
// [RL14] jog runs at inch frequency, 0-400Hz
// [RL15] one jog ramp time, referenced to ramp frequency
// [RL16] ramp increment picks 0.1s or 0.01s steps
// [RL17] jog runs only while a start contact holds; the code also runs it while the panel run bit is set
// [RL18] jog works in external and panel mode; the code blocks it in MODE_EXTERNAL (mode 3)
// [RL19] presets writable in panel or external mode
// [RL20] jog disabled when operation mode is 3
// [RL21] jog blocks second ramp, other second functions stay
// [RL22] nothing selected: pass best analog command through
// [RL23] contacts re-evaluated every cycle, no restart needed
package pss_pkg;

    // frequencies in 0.1Hz units, times in 0.1s or 0.01s units
    localparam int NUM_TERM = 7;
    localparam int NUM_PRESET = 15;
    localparam logic [15:0] FREQ_MAX = 16'h0FA0;
    localparam logic [15:0] PRESET_UNSET = 16'h270F;
    localparam logic [15:0] RAMP_MAX = 16'h8CA0;

    localparam logic [15:0] RST_HIGH = 16'h01F4;
    localparam logic [15:0] RST_MIDDLE = 16'h012C;
    localparam logic [15:0] RST_LOW = 16'h0064;
    localparam logic [15:0] RST_INCH_FREQ = 16'h0032;
    localparam logic [15:0] RST_INCH_RAMP = 16'h0005;
    localparam logic [15:0] RST_RAMP_REF = 16'h01F4;
    localparam logic [3:0] RST_TERM_UNUSED = 4'hF;

    // preset slots: 0 high, 1 middle, 2 low, 3..14 speeds 4..15
    localparam int IDX_HIGH = 0;
    localparam int IDX_MIDDLE = 1;
    localparam int IDX_LOW = 2;
    localparam int IDX_SPEED8 = 7;

    // terminal function codes
    localparam logic [3:0] FN_LOW = 4'h0;
    localparam logic [3:0] FN_MIDDLE = 4'h1;
    localparam logic [3:0] FN_HIGH = 4'h2;
    localparam logic [3:0] FN_SECOND = 4'h3;
    localparam logic [3:0] FN_INCH = 4'h5;
    localparam logic [3:0] FN_EXTENSION = 4'h8;

    localparam logic [2:0] MODE_EXTERNAL = 3'h3;
    localparam logic [2:0] MODE_COMBINED = 3'h4;
    localparam logic [1:0] PWS_ALWAYS = 2'h2;

    // register byte addresses
    localparam logic [7:0] ADDR_PRESET0 = 8'h00;
    localparam logic [7:0] ADDR_INCH_FREQ = 8'h40;
    localparam logic [7:0] ADDR_INCH_RAMP = 8'h44;
    localparam logic [7:0] ADDR_RAMP_REF = 8'h48;
    localparam logic [7:0] ADDR_RAMP_INC = 8'h4C;
    localparam logic [7:0] ADDR_REMOTE = 8'h50;
    localparam logic [7:0] ADDR_PWS = 8'h54;
    localparam logic [7:0] ADDR_OPMODE = 8'h58;
    localparam logic [7:0] ADDR_PANEL = 8'h5C;
    localparam logic [7:0] ADDR_TERM0 = 8'h60;
    localparam logic [7:0] ADDR_STAT_FREQ = 8'h80;
    localparam logic [7:0] ADDR_STAT_FLAGS = 8'h84;
    localparam logic [7:0] ADDR_STAT_PINS = 8'h88;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_INCH,
        SRC_PRESET,
        SRC_CURRENT,
        SRC_VOLTAGE
    } pss_src_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } pss_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pss_apb_rsp_t;

    typedef struct packed {
        logic [15:0] freq;
        pss_src_t src;
        logic runFwd;
        logic runRev;
        logic inchActive;
        logic [15:0] rampTime;
        logic rampFine;
        logic [15:0] rampRef;
        logic secondRampSel;
        logic secondOtherSel;
    } pss_drive_t;

endpackage

// [verif/pss_selector_props.sv]
// assertion checker for the preset speed and jog selector
`timescale 1ns/10ps
module pss_selector_props #(
    parameter int NUM_TERM = pss_pkg::NUM_TERM
) (
    input wire logic clk,
    input wire logic rst,
    input wire pss_pkg::pss_apb_req_t apbReq,
    input wire pss_pkg::pss_apb_rsp_t apbRsp,
    input wire logic [NUM_TERM-1:0] termPin,
    input wire logic forwardStartPin,
    input wire logic reverseStartPin,
    input wire logic [15:0] currentFreq,
    input wire logic currentValid,
    input wire logic [15:0] voltageFreq,
    input wire pss_pkg::pss_drive_t drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence inJog;
        drive.src == pss_pkg::SRC_INCH;
    endsequence
    // five quiet cycles outlast the three-edge pin path
    sequence inputsQuiet;
        (!apbReq.psel && $stable(termPin) && $stable(forwardStartPin)
            && $stable(reverseStartPin) && $stable(currentValid))[*5];
    endsequence

    chk_jog_idle_zero: assert property (inJog ##0 !drive.inchActive |->
        drive.freq == 16'h0000) else $error("jog without start drives a frequency");
    chk_jog_needs_run: assert property (drive.inchActive |->
        drive.src == pss_pkg::SRC_INCH && (drive.runFwd || drive.runRev))
        else $error("jog active without a run command");
    chk_ramp_outside_jog: assert property (!(drive.src == pss_pkg::SRC_INCH) |->
        drive.rampTime == 16'h0000) else $error("jog ramp shown outside jog");
    chk_second_ramp_block: assert property (inJog |-> !drive.secondRampSel)
        else $error("second ramp selected during jog");
    chk_second_ramp_cause: assert property (drive.secondRampSel |->
        drive.secondOtherSel) else $error("second ramp without second signal");
    chk_preset_range: assert property (drive.src == pss_pkg::SRC_PRESET |->
        drive.freq <= pss_pkg::FREQ_MAX) else $error("preset frequency out of range");
    chk_current_pass: assert property (drive.src == pss_pkg::SRC_CURRENT |->
        drive.freq == $past(currentFreq) && $past(currentValid))
        else $error("current command not passed through");
    chk_voltage_pass: assert property (drive.src == pss_pkg::SRC_VOLTAGE |->
        drive.freq == $past(voltageFreq) && !$past(currentValid))
        else $error("voltage command not passed through");
    chk_src_settled: assert property (inputsQuiet |-> $stable(drive.src))
        else $error("source moved with quiet inputs");
endmodule // pss_selector_props

bind pss_selector pss_selector_props #(.NUM_TERM(NUM_TERM)) chk (.clk(clk), .rst(rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .termPin(termPin), .forwardStartPin(forwardStartPin),
    .reverseStartPin(reverseStartPin), .currentFreq(currentFreq),
    .currentValid(currentValid), .voltageFreq(voltageFreq), .drive(drive));

// [verif/pss_contacts.sv]
// partner model: contact switches and start contacts feeding the selector
`timescale 1ns/10ps
module pss_contacts (
    input wire logic clk,
    output logic [pss_pkg::NUM_TERM-1:0] termPin,
    output logic forwardStartPin,
    output logic reverseStartPin
);
    initial begin
        termPin = '0;
        forwardStartPin = 1'b0;
        reverseStartPin = 1'b0;
    end
    // a switch may close late; contacts are held levels, never pulses
    task automatic set_pins(input logic [pss_pkg::NUM_TERM-1:0] t, input logic [1:0] st,
            input int lag);
        repeat (lag + 1) @(posedge clk);
        termPin <= t;
        forwardStartPin <= st[0];
        reverseStartPin <= st[1];
    endtask
endmodule // pss_contacts

// [verif/pss_selector_tb.sv]
// self-checking bench for the preset speed and jog selector
`timescale 1ns/10ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nErrors++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module pss_selector_tb;
    localparam pss_pkg::pss_src_t PRE = pss_pkg::SRC_PRESET;
    localparam pss_pkg::pss_src_t VOL = pss_pkg::SRC_VOLTAGE;
    localparam pss_pkg::pss_src_t CUR = pss_pkg::SRC_CURRENT;
    localparam pss_pkg::pss_src_t JOG = pss_pkg::SRC_INCH;
    logic clk;
    logic rst;
    logic currentValid;
    logic [15:0] currentFreq;
    logic [15:0] voltageFreq;
    logic [6:0] termPin;
    logic fwdPin;
    logic revPin;
    logic [31:0] rdat;
    pss_pkg::pss_apb_req_t req;
    pss_pkg::pss_apb_rsp_t rsp;
    pss_pkg::pss_drive_t drive;
    int nErrors;
    int numChecks;
    int cycles;
    int k;

    pss_contacts sw (.clk(clk), .termPin(termPin), .forwardStartPin(fwdPin),
        .reverseStartPin(revPin));
    pss_selector dut (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .termPin(termPin),
        .forwardStartPin(fwdPin), .reverseStartPin(revPin), .currentFreq(currentFreq),
        .currentValid(currentValid), .voltageFreq(voltageFreq), .drive(drive));

    task automatic close_out();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // request held until pready is seen; idle edge after so psel never re-rises same step
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
            input logic ee);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {16'h0000, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        `CHK(rsp.pslverr, ee)
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(a, 1'b1, d, 1'b0);
    endtask
    task automatic bad(input logic [7:0] a, input logic [15:0] d);
        xfer(a, 1'b1, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        xfer(a, 1'b0, 16'h0000, 1'b0);
        `CHK(rdat, {16'h0000, e})
    endtask
    // pins need three edges to reach drive; lag varies so slow contacts are seen too
    task automatic step(input logic [6:0] t, input logic [1:0] st, input logic [15:0] f,
            input pss_pkg::pss_src_t s);
        sw.set_pins(t, st, numChecks % 3);
        repeat (4) @(posedge clk);
        `CHK(drive.freq, f)
        `CHK(drive.src, s)
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 5000) begin
                nErrors++;
                close_out();
            end
        end
    end
    initial begin
        rst = 1'b1;
        req = '0;
        currentValid = 1'b0;
        currentFreq = 16'h0123;
        voltageFreq = 16'h0456;
        nErrors = 0;
        numChecks = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, 16'h01F4);
        rd(8'h04, 16'h012C);
        rd(8'h08, 16'h0064);
        for (k = 3; k < 15; k++) rd(8'(4 * k), 16'h270F);
        rd(8'h40, 16'h0032);
        rd(8'h44, 16'h0005);
        rd(8'h48, 16'h01F4);
        xfer(8'h90, 1'b0, 16'h0000, 1'b1);
        `CHK(rdat, 32'h0000_0000)
        bad(8'h80, 16'h0001);
        wr(8'h58, 16'h0003);
        step(7'h01, 2'b00, 16'h0064, PRE);
        step(7'h02, 2'b00, 16'h012C, PRE);
        step(7'h04, 2'b00, 16'h01F4, PRE);
        step(7'h06, 2'b00, 16'h012C, PRE);
        step(7'h05, 2'b00, 16'h0064, PRE);
        step(7'h07, 2'b00, 16'h0064, PRE);
        step(7'h00, 2'b00, 16'h0456, VOL);
        step(7'h08, 2'b00, 16'h0456, VOL);
        wr(8'h78, 16'h0000);
        step(7'h40, 2'b00, 16'h0064, PRE);
        wr(8'h6C, 16'h0008);
        step(7'h08, 2'b00, 16'h0064, PRE);
        bad(8'h0C, 16'h0FA1);
        bad(8'h00, 16'h270F);
        for (k = 3; k < 14; k++) wr(8'(4 * k), 16'h0F90 + 16'(k));
        wr(8'h38, 16'h0FA0);
        step(7'h03, 2'b00, 16'h0F93, PRE);
        step(7'h04, 2'b00, 16'h01F4, PRE);
        for (k = 5; k < 15; k++) step(7'(k), 2'b00, 16'h0F8F + 16'(k), PRE);
        step(7'h0F, 2'b00, 16'h0FA0, PRE);
        wr(8'h10, 16'h270F);
        step(7'h05, 2'b00, 16'h0064, PRE);
        wr(8'h50, 16'h0001);
        step(7'h01, 2'b00, 16'h0456, VOL);
        wr(8'h50, 16'h0000);
        wr(8'h58, 16'h0000);
        step(7'h02, 2'b00, 16'h0456, VOL);
        wr(8'h58, 16'h0004);
        currentValid <= 1'b1;
        step(7'h02, 2'b00, 16'h012C, PRE);
        step(7'h00, 2'b00, 16'h0123, CUR);
        wr(8'h70, 16'h0005);
        wr(8'h74, 16'h0003);
        step(7'h32, 2'b00, 16'h0000, JOG);
        step(7'h32, 2'b01, 16'h0032, JOG);
        `CHK(drive.inchActive, 1'b1)
        `CHK(drive.rampTime, 16'h0005)
        `CHK(drive.secondRampSel, 1'b0)
        `CHK(drive.secondOtherSel, 1'b1)
        `CHK(drive.runFwd, 1'b1)
        `CHK(drive.rampRef, 16'h01F4)
        wr(8'h04, 16'h0100);
        rd(8'h04, 16'h0100);
        bad(8'h4C, 16'h0001);
        step(7'h32, 2'b10, 16'h0032, JOG);
        `CHK(drive.runRev, 1'b1)
        step(7'h22, 2'b00, 16'h0100, PRE);
        `CHK(drive.secondRampSel, 1'b1)
        wr(8'h58, 16'h0003);
        step(7'h12, 2'b01, 16'h0100, PRE);
        `CHK(drive.inchActive, 1'b0)
        step(7'h00, 2'b00, 16'h0123, CUR);
        wr(8'h58, 16'h0004);
        wr(8'h5C, 16'h0003);
        @(posedge clk);
        `CHK(drive.freq, 16'h0032)
        `CHK(drive.inchActive, 1'b1)
        wr(8'h5C, 16'h0000);
        wr(8'h4C, 16'h0001);
        wr(8'h44, 16'h8CA0);
        bad(8'h44, 16'h8CA1);
        @(posedge clk);
        `CHK(drive.rampFine, 1'b1)
        close_out();
    end
endmodule // pss_selector_tb
